// [shared/chp_pkg.sv]
// Constants and carrier types for the command FIFO host port.
// Assumes one core clock domain; host and DMA sides are on-chip logic.
package chp_pkg;

    // ------------------------------------------------------------
    // Host window and command stream layout
    // ------------------------------------------------------------
    localparam logic [15:0] WIN_LO = 16'h2000;  // Aliased FIFO window low
    localparam logic [15:0] WIN_HI = 16'h2FFF;  // Aliased FIFO window high
    localparam int TAG_MODE_HI = 31;             // Tag word: mode field
    localparam int TAG_MODE_LO = 30;
    localparam int TAG_CNT_HI = 23;              // Tag word: data word count
    localparam int TAG_CNT_LO = 16;
    localparam int TAG_ADR_HI = 11;              // Tag word: register address
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_INDEX = 2'h1;
    localparam logic [1:0] MODE_HOLD = 2'h2;

    // ------------------------------------------------------------
    // Command register addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADR_RENDER = 12'h0008;
    localparam logic [11:0] ADR_CONT_LINE = 12'h0009;
    localparam logic [11:0] ADR_CONT_DOM = 12'h000A;
    localparam logic [11:0] ADR_SYNC = 12'h0188;

    // ------------------------------------------------------------
    // Sizes and counts
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_W = 32;
    localparam logic [4:0] DMA_MIN_FREE = 5'h02; // Slots needed to fetch
    localparam logic [31:0] DMA_STEP = 32'h0000_0004;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] data;
    } chp_hwr_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
    } chp_regwr_s;

    typedef enum logic [2:0] {
        ST_TAG = 3'b001,
        ST_DATA = 3'b010,
        ST_SYNC = 3'b100
    } chp_dec_e;

endpackage : chp_pkg

// [core/chp_host_port.sv]
// Command FIFO host port: host window writes and DMA into a FIFO,
// then tag/data decode into register writes toward the pipeline.
// Assumes host, DMA and pipeline logic share core_clk.
// Summary of operation
// - Every word in the aliased window pushes into the one command FIFO.
// - Disconnect mode: write to full FIFO is disconnected, data kept.
// - Free FIFO entry count is readable for polling hosts.
// - Direct loading: a register address word, then its data value.
// - Indexed mode: one address word, then data for a register group.
// - Hold mode: one address word, many data values to one register.
// - DMA engine fetches host memory into the FIFO without polling.
// - DMA completion raises an interrupt event.
// - Texture miss raises an interrupt so host can download the map.
// - AGP slot: single-edge read master, optional sideband addressing.
// - Control registers keep values across primitives until rewritten.
// - Render plus its continue commands stay atomic against context.
// - Sync makes earlier memory writes finish before later reads.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Generic FIFO
// ----------------------------------------------------------------
module chp_fifo import chp_pkg::*; #(
    parameter int W = WORD_W,
    parameter int D = FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    // Occupancy
    output logic [$clog2(D):0] free
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("FIFO depth must be 2^n");
    end

    // Handshakes and flags
    assign in_ready = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready && ce;
    assign pop = out_valid && out_ready && ce;
    assign out_data = mem[rp_q];
    assign free = (AW+1)'(D) - cnt_q;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + AW'(1);
            if (pop) rp_q <= rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : chp_fifo

// ----------------------------------------------------------------
// Host port top
// ----------------------------------------------------------------
module chp_host_port import chp_pkg::*; (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Mode pins
    input wire logic disconnect_en,
    input wire logic agp_slot,
    input wire logic agp_sideband_en,
    // Host target writes into region 0
    input wire logic hw_req,
    input wire chp_hwr_s hw_wr,
    output logic hw_ack,
    output logic hw_disconnect,
    output logic [4:0] input_fifo_free_count,
    // DMA control
    input wire logic dma_go,
    input wire logic [31:0] dma_base,
    input wire logic [15:0] dma_words,
    output logic dma_busy,
    output logic dma_irq,
    // Bus master reads
    output logic mrd_req,
    output logic [31:0] mrd_addr,
    output logic mrd_agp_1x,
    output logic mrd_sideband,
    input wire logic mrd_valid,
    input wire logic [31:0] mrd_data,
    // Pipeline register writes
    output logic rw_valid,
    output chp_regwr_s rw,
    input wire logic rw_ready,
    // Memory ordering, texture events and primitive lock
    output logic mem_fence,
    input wire logic mem_wr_idle,
    input wire logic tex_miss,
    output logic tex_irq,
    output logic primitive_open
);
    logic [1:0] rst_sync_q, disc_s_q, agp_s_q, sba_s_q;
    logic rst_n;
    logic fin_valid, fin_ready;
    logic [31:0] fin_data;
    logic fout_valid, fout_ready;
    logic [31:0] fout_data;
    logic [4:0] ffree;
    logic in_win, hw_take, dma_out_q;
    logic [15:0] dma_left_q;
    chp_dec_e st_q;
    logic [1:0] mode_q;
    logic [7:0] left_q;
    logic [11:0] addr_q;
    logic slot_free, is_cont;

    // Address decode shared by host write paths
    function automatic logic win_hit(input logic [15:0] a);
        return (a >= WIN_LO) && (a <= WIN_HI);
    endfunction : win_hit

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) rst_sync_q <= 2'h0;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Mode pin synchronisers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            disc_s_q <= 2'h0;
            agp_s_q <= 2'h0;
            sba_s_q <= 2'h0;
        end else if (ce) begin
            disc_s_q <= {disc_s_q[0], disconnect_en};
            agp_s_q <= {agp_s_q[0], agp_slot};
            sba_s_q <= {sba_s_q[0], agp_sideband_en};
        end
    end

    // ------------------------------------------------------------
    // FIFO fill: DMA data first, then host window writes
    // ------------------------------------------------------------
    assign in_win = win_hit(hw_wr.addr);
    assign hw_take = hw_req && !hw_ack && !hw_disconnect && !mrd_valid
        && (!dma_out_q || ffree > 5'h01); // Slot kept for DMA return
    assign fin_valid = mrd_valid || (hw_take && in_win);
    assign fin_data = mrd_valid ? mrd_data : hw_wr.data;

    chp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(fin_valid),
        .in_ready(fin_ready),
        .in_data(fin_data),
        .out_valid(fout_valid),
        .out_ready(fout_ready),
        .out_data(fout_data),
        .free(ffree)
    );

    // Host response: accept, disconnect on full, or wait
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_ack <= 1'b0;
            hw_disconnect <= 1'b0;
            input_fifo_free_count <= 5'h00;
        end else if (ce) begin
            input_fifo_free_count <= ffree;
            hw_ack <= hw_take && (!in_win || fin_ready);
            hw_disconnect <= hw_take && in_win && !fin_ready
                && disc_s_q[1];
        end
    end

    // ------------------------------------------------------------
    // DMA engine: one word outstanding, space reserved first
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_busy <= 1'b0;
            dma_left_q <= 16'h0000;
            dma_out_q <= 1'b0;
            mrd_req <= 1'b0;
            mrd_addr <= 32'h0000_0000;
            dma_irq <= 1'b0;
        end else if (ce) begin
            mrd_req <= 1'b0;
            dma_irq <= 1'b0;
            if (!dma_busy && dma_go && dma_words != 16'h0000) begin
                dma_busy <= 1'b1;
                dma_left_q <= dma_words;
                mrd_addr <= dma_base;
            end else if (dma_busy && !dma_out_q && !mrd_req
                && ffree >= DMA_MIN_FREE) begin
                mrd_req <= 1'b1;
                dma_out_q <= 1'b1;
            end else if (dma_out_q && mrd_valid) begin
                dma_out_q <= 1'b0;
                mrd_addr <= mrd_addr + DMA_STEP;
                dma_left_q <= dma_left_q - 16'h0001;
                if (dma_left_q == 16'h0001) begin
                    dma_busy <= 1'b0;
                    dma_irq <= 1'b1;
                end
            end
        end
    end

    // AGP transfer attributes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mrd_agp_1x <= 1'b0;
            mrd_sideband <= 1'b0;
        end else if (ce) begin
            mrd_agp_1x <= agp_s_q[1];
            mrd_sideband <= agp_s_q[1] && sba_s_q[1];
        end
    end

    // Texture miss event
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) tex_irq <= 1'b0;
        else if (ce) tex_irq <= tex_miss;
    end

    // ------------------------------------------------------------
    // Decoder: tag word then data words
    // ------------------------------------------------------------
    assign slot_free = !rw_valid || rw_ready;
    assign fout_ready = (st_q == ST_TAG) || (st_q == ST_DATA && slot_free);
    assign is_cont = (addr_q == ADR_CONT_LINE) || (addr_q == ADR_CONT_DOM);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_TAG;
            mode_q <= MODE_SINGLE;
            left_q <= 8'h00;
            addr_q <= 12'h000;
        end else if (ce) begin
            case (st_q)
                ST_TAG: begin
                    if (fout_valid) begin
                        mode_q <= fout_data[TAG_MODE_HI:TAG_MODE_LO];
                        addr_q <= fout_data[TAG_ADR_HI:0];
                        left_q <= (fout_data[TAG_MODE_HI:TAG_MODE_LO]
                            == MODE_SINGLE
                            || fout_data[TAG_CNT_HI:TAG_CNT_LO] == 8'h00)
                            ? 8'h01 : fout_data[TAG_CNT_HI:TAG_CNT_LO];
                        st_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (fout_valid && slot_free) begin
                        left_q <= left_q - 8'h01;
                        if (mode_q == MODE_INDEX) begin
                            addr_q <= addr_q + 12'h001;
                        end
                        // Hold mode keeps the address.
                        if (addr_q == ADR_SYNC) st_q <= ST_SYNC;
                        else if (left_q == 8'h01) st_q <= ST_TAG;
                    end
                end
                ST_SYNC: begin
                    // Later reads wait for earlier writes.
                    if (mem_wr_idle && !mem_fence) begin
                        st_q <= (left_q == 8'h00) ? ST_TAG : ST_DATA;
                    end
                end
                default: st_q <= ST_TAG;
            endcase
        end
    end

    // Register write output; held until taken, then replaced by the next write or rw_valid clears
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rw_valid <= 1'b0;
            rw <= '0;
        end else if (ce) begin
            if (st_q == ST_DATA && fout_valid && slot_free) begin
                rw_valid <= 1'b1;
                rw.addr <= addr_q;
                rw.data <= fout_data;
            end else if (rw_ready) begin
                rw_valid <= 1'b0;
            end
        end
    end

    // Sync fence pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) mem_fence <= 1'b0;
        else if (ce) begin
            mem_fence <= st_q == ST_DATA && fout_valid && slot_free
                && addr_q == ADR_SYNC;
        end
    end

    // Primitive lock against context switches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) primitive_open <= 1'b0;
        else if (ce) begin
            if (st_q == ST_DATA && fout_valid && slot_free
                && (addr_q == ADR_RENDER || is_cont)) begin
                primitive_open <= 1'b1;
            end else if (!fout_valid && !fin_valid && st_q == ST_TAG) begin
                primitive_open <= 1'b0;
            end
        end
    end
endmodule : chp_host_port

// [test/chp_host_port_properties.sv]
// Checker on the host port top-level ports.
// Assumes one core_clk domain and active-low rstn.
`timescale 1ns/1ps
module chp_host_port_properties import chp_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Host writes
    input wire logic hw_req,
    input wire logic hw_ack,
    input wire logic hw_disconnect,
    input wire logic [4:0] input_fifo_free_count,
    // DMA and reads
    input wire logic dma_go,
    input wire logic [15:0] dma_words,
    input wire logic dma_busy,
    input wire logic dma_irq,
    input wire logic mrd_req,
    // Register writes, events and AGP mode
    input wire logic rw_valid,
    input wire chp_regwr_s rw,
    input wire logic rw_ready,
    input wire logic tex_miss,
    input wire logic tex_irq,
    input wire logic agp_slot,
    input wire logic mrd_agp_1x
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // One answer, then a quiet cycle
    sequence s_answer;
        (hw_ack ^ hw_disconnect) ##1 !(hw_ack || hw_disconnect);
    endsequence
    // Engine idle with no read in flight
    sequence s_dma_idle;
        !dma_busy && !mrd_req;
    endsequence
    a_ack_has_req: assert property (hw_ack |-> $past(hw_req))
        else $error("ack without request");
    a_one_answer: assert property (
        (hw_ack || hw_disconnect) |-> s_answer)
        else $error("bad answer pulse");
    a_disc_when_full: assert property (
        hw_disconnect |-> input_fifo_free_count <= 5'h01)
        else $error("disconnect with free slots");
    a_rw_holds: assert property (
        rw_valid && !rw_ready |=> rw_valid && $stable(rw))
        else $error("register write dropped");
    a_dma_starts: assert property (
        dma_go && !dma_busy && dma_words != 16'h0000 |=> dma_busy)
        else $error("dma did not start");
    a_read_in_dma: assert property (
        mrd_req |-> dma_busy ##1 !mrd_req)
        else $error("read outside dma");
    a_irq_at_end: assert property (
        dma_irq |-> s_dma_idle ##0 $past(dma_busy) ##1 !dma_irq)
        else $error("dma interrupt misplaced");
    a_tex_follows: assert property (tex_irq == $past(tex_miss))
        else $error("texture interrupt wrong");
    a_agp_follows: assert property (
        $stable(agp_slot) [*6] |-> mrd_agp_1x == agp_slot)
        else $error("agp mode not followed");
endmodule : chp_host_port_properties

bind chp_host_port chp_host_port_properties chp_host_port_properties_i (
    .core_clk, .rstn, .hw_req, .hw_ack, .hw_disconnect,
    .input_fifo_free_count, .dma_go, .dma_words, .dma_busy, .dma_irq,
    .mrd_req, .rw_valid, .rw, .rw_ready, .tex_miss, .tex_irq, .agp_slot,
    .mrd_agp_1x
);

// [test/chp_host_mem_model.sv]
// Host memory answering one-word master reads lat+1 cycles after the request.
// Assumes one read outstanding; data line churns when idle.
`timescale 1ns/1ps
module chp_host_mem_model import chp_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Answer delay
    input wire logic [3:0] lat,
    // Read request and return
    input wire logic mrd_req,
    input wire logic [31:0] mrd_addr,
    output logic mrd_valid,
    output logic [31:0] mrd_data
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [31:0] adr_q;
    // Even words hold a tag, odd words the inverted address
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            adr_q <= 32'h0000_0000;
            mrd_valid <= 1'b0;
            mrd_data <= 32'h0000_0000;
        end else begin
            mrd_valid <= 1'b0;
            mrd_data <= ~mrd_data; // Released line, no stale value
            if (mrd_req) begin
                busy_q <= 1'b1;
                adr_q <= mrd_addr;
                cnt_q <= lat;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                mrd_valid <= 1'b1;
                mrd_data <= adr_q[2] ? ~adr_q
                    : {MODE_SINGLE, 18'h0_0000, 12'h040};
            end
        end
    end
endmodule : chp_host_mem_model

// [test/testbench.sv]
// Self-checking bench: window writes, modes, disconnect, DMA, sync.
// Assumes the checker bind and the host memory model are compiled.
`timescale 1ns/1ps
module testbench import chp_pkg::*;;
    logic core_clk = 0, rstn = 0, ce = 1, disconnect_en = 0;
    logic agp_slot = 0, agp_sideband_en = 0, hw_req = 0, dma_go = 0;
    logic rw_ready = 1, mem_wr_idle = 1, tex_miss = 0;
    logic [3:0] lat = 4'h0;
    logic [15:0] wa = 16'h0000, dma_words = 16'h0000;
    logic [31:0] dma_base = 32'h0000_0000, mrd_addr, mrd_data;
    chp_hwr_s hw_wr = '0;
    logic hw_ack, hw_disconnect, dma_busy, dma_irq, mrd_req, mrd_agp_1x;
    logic mrd_sideband, mrd_valid, rw_valid, mem_fence, tex_irq;
    logic primitive_open;
    logic [4:0] input_fifo_free_count;
    chp_regwr_s rw;
    chp_regwr_s expq[$];
    int miscompares = 0, n_checks = 0, n_fence = 0, n_dma = 0;
    int n_tex = 0, n_disc = 0;

    always #2 core_clk = ~core_clk;

    chp_host_port chp_host_port_i (.core_clk, .rstn, .ce, .disconnect_en,
        .agp_slot, .agp_sideband_en, .hw_req, .hw_wr, .hw_ack,
        .hw_disconnect, .input_fifo_free_count, .dma_go, .dma_base,
        .dma_words, .dma_busy, .dma_irq, .mrd_req, .mrd_addr, .mrd_agp_1x,
        .mrd_sideband, .mrd_valid, .mrd_data, .rw_valid, .rw, .rw_ready,
        .mem_fence, .mem_wr_idle, .tex_miss, .tex_irq, .primitive_open);
    chp_host_mem_model chp_host_mem_model_i (.core_clk, .rstn, .lat,
        .mrd_req, .mrd_addr, .mrd_valid, .mrd_data);

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task chk_rw(input chp_regwr_s got, input chp_regwr_s exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_rw
    // Collect register writes and event pulses
    always @(posedge core_clk) begin
        if (rw_valid === 1'b1 && rw_ready === 1'b1) begin
            chk_rw(rw, expq.pop_front());
        end
        n_fence += (mem_fence === 1'b1);
        n_dma += (dma_irq === 1'b1);
        n_tex += (tex_irq === 1'b1);
    end
    function logic [31:0] tag(logic [1:0] m, logic [7:0] n, logic [11:0] a);
        return {m, 6'h00, n, 4'h0, a};
    endfunction : tag
    // Window write, repeated while refused
    task put(input logic [31:0] d);
        int i;
        hw_wr = {wa, d};
        hw_req = 1;
        for (i = 0; i < 400; i++) begin
            @(negedge core_clk);
            n_disc += (hw_disconnect === 1'b1);
            if (hw_ack === 1'b1) break;
        end
        chk_word({31'h0, hw_ack}, 32'h1);
        hw_req = 0;
        wa = (wa == 16'h2FFC) ? WIN_LO : wa + 16'h0004;
        @(negedge core_clk);
    endtask : put
    task put_reg(input logic [11:0] a, input logic [31:0] d);
        put(tag(MODE_SINGLE, 8'h00, a));
        put(d);
        expq.push_back({a, d});
    endtask : put_reg
    task drain;
        int i;
        for (i = 0; i < 500 && expq.size() != 0; i++) @(negedge core_clk);
        chk_word(expq.size(), 0);
    endtask : drain
    task sc_direct;
        logic [7:0] i;
        wa = 16'h3000;
        put(tag(MODE_SINGLE, 8'h00, 12'h077));
        wa = 16'h2FFC;
        put_reg(12'h012, 32'h1234_5678);
        put(tag(MODE_INDEX, 8'h03, 12'h020));
        for (i = 0; i < 3; i++) begin
            put(32'h0000_00A0 + {24'h0, i});
            expq.push_back({12'h020 + {4'h0, i}, 32'h0000_00A0 + {24'h0, i}});
        end
        drain;
        chk_word(input_fifo_free_count, 32'h10);
    endtask : sc_direct
    task sc_full;
        logic [7:0] i;
        disconnect_en = 1;
        rw_ready = 0;
        wa = WIN_LO;
        repeat (4) @(negedge core_clk);
        fork
            begin
                repeat (150) @(negedge core_clk);
                rw_ready = 1;
            end
        join_none
        put(tag(MODE_HOLD, 8'd40, 12'h030));
        for (i = 0; i < 40; i++) begin
            put(32'hB000_0000 + {24'h0, i});
            expq.push_back({12'h030, 32'hB000_0000 + {24'h0, i}});
        end
        chk_word(n_disc != 0, 32'h1);
        drain;
        disconnect_en = 0;
    endtask : sc_full
    task sc_dma(input logic [3:0] l);
        int i, n;
        lat = l;
        n = n_dma;
        dma_base = 32'h0000_1000;
        dma_words = 16'h0004;
        dma_go = 1;
        @(negedge core_clk);
        dma_go = 0;
        expq.push_back({12'h040, ~32'h0000_1004});
        expq.push_back({12'h040, ~32'h0000_100C});
        for (i = 0; i < 300 && dma_busy === 1'b1; i++) @(negedge core_clk);
        @(negedge core_clk);
        chk_word(n_dma, n + 1);
        drain;
    endtask : sc_dma
    task sc_sync;
        mem_wr_idle = 0;
        rw_ready = 0; // Decode stalls just after the render write
        put_reg(ADR_RENDER, 32'h0000_0001);
        put_reg(ADR_SYNC, 32'h0000_0000);
        put_reg(ADR_CONT_LINE, 32'h0000_0002);
        chk_word(primitive_open, 1);
        rw_ready = 1;
        repeat (30) @(negedge core_clk);
        chk_word(expq.size(), 1);
        chk_word(n_fence, 1);
        chk_word(primitive_open, 1);
        mem_wr_idle = 1;
        drain;
        chk_word(primitive_open, 0);
    endtask : sc_sync
    task sc_events;
        tex_miss = 1;
        @(negedge core_clk);
        tex_miss = 0;
        repeat (2) @(negedge core_clk);
        chk_word(n_tex, 1);
        agp_slot = 1;
        agp_sideband_en = 1;
        repeat (8) @(negedge core_clk);
        chk_word({mrd_agp_1x, mrd_sideband}, 32'h3);
        agp_slot = 0;
        agp_sideband_en = 0;
    endtask : sc_events
    task finish_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (3) @(negedge core_clk);
        rstn = 1;
        repeat (4) @(negedge core_clk);
        sc_direct;
        sc_full;
        sc_dma(4'h0);
        sc_dma(4'h7);
        sc_sync;
        sc_events;
        finish_test;
    end
    // Watchdog
    initial begin
        #40000;
        miscompares++;
        finish_test;
    end
endmodule : testbench
